// File: design/pllds_pkg.sv
package pllds_pkg;

    // ------------------------------------------------------------
    // register offsets on the management bus
    // ------------------------------------------------------------
    localparam logic [7:0] PLLDS_OFS_PROG_EN   = 8'h0A;
    localparam logic [7:0] PLLDS_OFS_CPU_DIVHI = 8'h0B;
    localparam logic [7:0] PLLDS_OFS_CPU_FBLO  = 8'h0C;
    localparam logic [7:0] PLLDS_OFS_CPU_SPLO  = 8'h0D;
    localparam logic [7:0] PLLDS_OFS_CPU_SPHI  = 8'h0E;
    localparam logic [7:0] PLLDS_OFS_GFX_DIVHI = 8'h0F;
    localparam logic [7:0] PLLDS_OFS_GFX_FBLO  = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PLLDS_POS_PROG_EN = 7;  // enable bit in its byte
    localparam int PLLDS_POS_FB8     = 7;  // feedback bit 8
    localparam int PLLDS_POS_FB9     = 6;  // feedback bit 9
    localparam int PLLDS_REF_MSB     = 5;  // reference divider 5:0
    localparam int PLLDS_SPHI_MSB    = 6;  // spread high byte 6:0

    // ------------------------------------------------------------
    // widths, offsets of the frequency formula
    // ------------------------------------------------------------
    localparam int PLLDS_FB_W  = 10;
    localparam int PLLDS_REF_W = 6;
    localparam int PLLDS_SP_W  = 15;
    localparam logic [10:0] PLLDS_FB_ADD  = 11'h008;
    localparam logic [6:0]  PLLDS_REF_ADD = 7'h02;

    // ------------------------------------------------------------
    // reset values and bus constants
    // ------------------------------------------------------------
    localparam logic        PLLDS_RST_PROG_EN = 1'h0;
    localparam logic [14:0] PLLDS_RST_SPREAD  = 15'h0000;
    // bus address of this device; value is arbitrary
    localparam logic [6:0]  PLLDS_DEV_ADDR    = 7'h2A;
    // count byte sent ahead of block read data
    localparam logic [7:0]  PLLDS_RD_COUNT    = 8'h07;
    localparam logic [3:0]  PLLDS_BITS_BYTE   = 4'h8;

    // power-up default table, one entry per frequency select value
    // entry layout: {feedback[9:0], reference[5:0]}; values arbitrary
    localparam logic [15:0] PLLDS_DEF_TABLE [8] = '{
        16'h1C0C, 16'h1C0C, 16'h3E8C, 16'h420C,
        16'h1B0C, 16'h250C, 16'h2F0C, 16'h390C};

    typedef enum logic [2:0] {
        PLLDS_ST_IDLE  = 3'b000,
        PLLDS_ST_ADDR  = 3'b001,
        PLLDS_ST_CMD   = 3'b010,
        PLLDS_ST_CNT   = 3'b011,
        PLLDS_ST_WDATA = 3'b100,
        PLLDS_ST_RDATA = 3'b101
    } pllds_state_t;

endpackage : pllds_pkg

// File: design/pllds_cfg_if.sv
`timescale 1ns/100ps

// programmed divider fields passed to the apply stage
interface pllds_cfg_if;
    import pllds_pkg::*;
    logic [PLLDS_FB_W-1:0]  cpu_fb;
    logic [PLLDS_REF_W-1:0] cpu_ref;
    logic [PLLDS_FB_W-1:0]  gfx_fb;
    logic [PLLDS_REF_W-1:0] gfx_ref;
    logic [PLLDS_SP_W-1:0]  spread;
    logic                   prog_en;
    logic                   load_def;

    modport src  (output cpu_fb, cpu_ref, gfx_fb, gfx_ref, spread,
                  prog_en, load_def);
    modport sink (input  cpu_fb, cpu_ref, gfx_fb, gfx_ref, spread,
                  prog_en, load_def);
endinterface : pllds_cfg_if

// File: design/pllds_synth_apply.sv
`timescale 1ns/100ps

module pllds_synth_apply
    import pllds_pkg::*;
(
    // clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_resetn,
    // programmed fields
    pllds_cfg_if.sink          cfg,
    // applied synthesizer settings
    output logic [10:0]        o_cpu_mult,
    output logic [6:0]         o_cpu_div,
    output logic [10:0]        o_gfx_mult,
    output logic [6:0]         o_gfx_div,
    output logic [14:0]        o_cpu_spread
);

    // ------------------------------------------------------------
    // applied values
    // ------------------------------------------------------------

    // multiply by fb+8, divide by ref+2
    function automatic logic [10:0] fb_total(
        input logic [PLLDS_FB_W-1:0] fb);
        fb_total = {1'b0, fb} + PLLDS_FB_ADD;
    endfunction : fb_total

    function automatic logic [6:0] ref_total(
        input logic [PLLDS_REF_W-1:0] rd);
        ref_total = {1'b0, rd} + PLLDS_REF_ADD;
    endfunction : ref_total

    // apply only while enabled; power-up defaults always go through
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            o_cpu_mult   <= PLLDS_FB_ADD;
            o_cpu_div    <= PLLDS_REF_ADD;
            o_gfx_mult   <= PLLDS_FB_ADD;
            o_gfx_div    <= PLLDS_REF_ADD;
            o_cpu_spread <= PLLDS_RST_SPREAD;
        end
        else if (cfg.load_def || cfg.prog_en)
        begin
            o_cpu_mult   <= fb_total(cfg.cpu_fb);
            o_cpu_div    <= ref_total(cfg.cpu_ref);
            o_gfx_mult   <= fb_total(cfg.gfx_fb);
            o_gfx_div    <= ref_total(cfg.gfx_ref);
            o_cpu_spread <= cfg.spread;
        end
    end

endmodule : pllds_synth_apply

// File: design/pllds_regs.sv
`timescale 1ns/100ps

module pllds_regs
    import pllds_pkg::*;
(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // frequency select straps
    input  wire logic [2:0]  i_freq_sel,
    // management bus pins
    input  wire logic        i_smb_clk,
    input  wire logic        i_smb_data,
    output logic             o_smb_data_out,
    output logic             o_smb_data_oe,
    // applied synthesizer settings
    output logic [10:0]      o_cpu_mult,
    output logic [6:0]       o_cpu_div,
    output logic [10:0]      o_gfx_mult,
    output logic [6:0]       o_gfx_div,
    output logic [14:0]      o_cpu_spread,
    output logic             o_prog_en
);

    pllds_cfg_if cfg ();

    // ------------------------------------------------------------
    // pin sampling and bus conditions
    // ------------------------------------------------------------
    logic scl_reg, scl_prev_reg, sda_reg, sda_prev_reg;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            scl_reg      <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_reg      <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_reg      <= i_smb_clk;
            scl_prev_reg <= scl_reg;
            sda_reg      <= i_smb_data;
            sda_prev_reg <= sda_reg;
        end
    end

    // start and stop are data edges while the clock stays high
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_reg & ~scl_prev_reg;
    assign scl_fall  = ~scl_reg & scl_prev_reg;
    assign bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
    assign bus_stop  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic                   prog_en_reg;
    logic                   load_pend_reg;
    logic [PLLDS_FB_W-1:0]  cpu_fb_reg, gfx_fb_reg;
    logic [PLLDS_REF_W-1:0] cpu_ref_reg, gfx_ref_reg;
    logic [PLLDS_SP_W-1:0]  spread_reg;
    logic                   wr_stb;
    logic [7:0]             ptr_reg, shift_reg;

    // strap is caught one cycle after reset release, never under reset
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            load_pend_reg <= 1'b1;
        else
            load_pend_reg <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            prog_en_reg <= PLLDS_RST_PROG_EN;
        else if (wr_stb && ptr_reg == PLLDS_OFS_PROG_EN)
            prog_en_reg <= shift_reg[PLLDS_POS_PROG_EN];
    end

    // divider fields: table load at power-up, then host writes
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            cpu_fb_reg  <= '0;
            cpu_ref_reg <= '0;
            gfx_fb_reg  <= '0;
            gfx_ref_reg <= '0;
        end
        else if (load_pend_reg)
        begin
            // defaults picked by the live select straps
            {cpu_fb_reg, cpu_ref_reg} <= PLLDS_DEF_TABLE[i_freq_sel];
            {gfx_fb_reg, gfx_ref_reg} <= PLLDS_DEF_TABLE[i_freq_sel];
        end
        else if (wr_stb)
        begin
            case (ptr_reg)
                PLLDS_OFS_CPU_DIVHI:
                begin
                    cpu_fb_reg[8] <= shift_reg[PLLDS_POS_FB8];
                    cpu_fb_reg[9] <= shift_reg[PLLDS_POS_FB9];
                    cpu_ref_reg   <= shift_reg[PLLDS_REF_MSB:0];
                end
                PLLDS_OFS_CPU_FBLO: cpu_fb_reg[7:0] <= shift_reg;
                PLLDS_OFS_GFX_DIVHI:
                begin
                    gfx_fb_reg[8] <= shift_reg[PLLDS_POS_FB8];
                    gfx_fb_reg[9] <= shift_reg[PLLDS_POS_FB9];
                    gfx_ref_reg   <= shift_reg[PLLDS_REF_MSB:0];
                end
                PLLDS_OFS_GFX_FBLO: gfx_fb_reg[7:0] <= shift_reg;
                default: ;
            endcase
        end
    end

    // spread amount over two bytes; codes are taken as given
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            spread_reg <= PLLDS_RST_SPREAD;
        else if (wr_stb && ptr_reg == PLLDS_OFS_CPU_SPLO)
            spread_reg[7:0] <= shift_reg;
        else if (wr_stb && ptr_reg == PLLDS_OFS_CPU_SPHI)
            spread_reg[14:8] <= shift_reg[PLLDS_SPHI_MSB:0];
    end

    // read back as stored, reserved and unmapped read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] ofs);
        rd_byte = 8'h00;
        case (ofs)
            PLLDS_OFS_PROG_EN:   rd_byte[PLLDS_POS_PROG_EN] = prog_en_reg;
            PLLDS_OFS_CPU_DIVHI: rd_byte = {cpu_fb_reg[8], cpu_fb_reg[9],
                                            cpu_ref_reg};
            PLLDS_OFS_CPU_FBLO:  rd_byte = cpu_fb_reg[7:0];
            PLLDS_OFS_CPU_SPLO:  rd_byte = spread_reg[7:0];
            PLLDS_OFS_CPU_SPHI:  rd_byte = {1'b0, spread_reg[14:8]};
            PLLDS_OFS_GFX_DIVHI: rd_byte = {gfx_fb_reg[8], gfx_fb_reg[9],
                                            gfx_ref_reg};
            PLLDS_OFS_GFX_FBLO:  rd_byte = gfx_fb_reg[7:0];
            default:             rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    // ------------------------------------------------------------
    // management bus slave
    // ------------------------------------------------------------
    pllds_state_t state_reg;
    logic [3:0]   bit_cnt_reg;
    logic         ack_ph_reg;
    logic [7:0]   tx_reg;
    logic         byte_end;

    assign byte_end = scl_fall & ~ack_ph_reg &
                      (bit_cnt_reg == PLLDS_BITS_BYTE);
    assign wr_stb   = byte_end & (state_reg == PLLDS_ST_WDATA);

    // byte framing, ack and read shifting; a block write is
    // command, count, data, and the count is not checked
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            state_reg     <= PLLDS_ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            ack_ph_reg    <= 1'b0;
            shift_reg     <= 8'h00;
            tx_reg        <= 8'h00;
            ptr_reg       <= 8'h00;
            o_smb_data_oe <= 1'b0;
        end
        else if (bus_start)
        begin
            // pointer kept so a repeated start can read
            state_reg     <= PLLDS_ST_ADDR;
            bit_cnt_reg   <= 4'h0;
            ack_ph_reg    <= 1'b0;
            o_smb_data_oe <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_reg     <= PLLDS_ST_IDLE;
            o_smb_data_oe <= 1'b0;
        end
        else if (state_reg == PLLDS_ST_IDLE)
            o_smb_data_oe <= 1'b0;
        else if (scl_rise)
        begin
            if (!ack_ph_reg)
            begin
                shift_reg   <= {shift_reg[6:0], sda_reg};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (state_reg == PLLDS_ST_RDATA && !o_smb_data_oe)
            begin
                // host nack ends the read; ack fetches next byte;
                // our own address ack is skipped so the count goes first
                if (sda_reg)
                    state_reg <= PLLDS_ST_IDLE;
                else
                begin
                    tx_reg  <= rd_byte(ptr_reg);
                    ptr_reg <= ptr_reg + 8'h01;
                end
            end
        end
        else if (byte_end)
        begin
            bit_cnt_reg <= 4'h0;
            ack_ph_reg  <= 1'b1;
            o_smb_data_oe <= (state_reg != PLLDS_ST_RDATA);
            case (state_reg)
                PLLDS_ST_ADDR:
                begin
                    if (shift_reg[7:1] != PLLDS_DEV_ADDR)
                    begin
                        state_reg     <= PLLDS_ST_IDLE;
                        o_smb_data_oe <= 1'b0;
                    end
                    else if (shift_reg[0])
                    begin
                        state_reg <= PLLDS_ST_RDATA;
                        tx_reg    <= PLLDS_RD_COUNT;
                    end
                    else
                        state_reg <= PLLDS_ST_CMD;
                end
                PLLDS_ST_CMD:
                begin
                    ptr_reg   <= shift_reg;
                    state_reg <= PLLDS_ST_CNT;
                end
                PLLDS_ST_CNT:   state_reg <= PLLDS_ST_WDATA;
                PLLDS_ST_WDATA: ptr_reg   <= ptr_reg + 8'h01;
                default: ;
            endcase
        end
        else if (scl_fall && ack_ph_reg)
        begin
            // ack slot over: release, or drive first read bit
            ack_ph_reg    <= 1'b0;
            o_smb_data_oe <= (state_reg == PLLDS_ST_RDATA) & ~tx_reg[7];
        end
        else if (scl_fall && state_reg == PLLDS_ST_RDATA)
        begin
            tx_reg        <= {tx_reg[6:0], 1'b0};
            o_smb_data_oe <= ~tx_reg[6];
        end
    end

    // open drain: only ever pull low
    always_ff @(posedge i_core_clk)
    begin
        o_smb_data_out <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            o_prog_en <= PLLDS_RST_PROG_EN;
        else
            o_prog_en <= prog_en_reg;
    end

    // ------------------------------------------------------------
    // apply stage
    // ------------------------------------------------------------
    assign cfg.cpu_fb   = cpu_fb_reg;
    assign cfg.cpu_ref  = cpu_ref_reg;
    assign cfg.gfx_fb   = gfx_fb_reg;
    assign cfg.gfx_ref  = gfx_ref_reg;
    assign cfg.spread   = spread_reg;
    assign cfg.prog_en  = prog_en_reg;
    logic def_apply_reg;

    // table values land one cycle after the strap capture
    assign cfg.load_def = def_apply_reg;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            def_apply_reg <= 1'b0;
        else
            def_apply_reg <= load_pend_reg;
    end

    pllds_synth_apply u_apply (
        .i_core_clk   (i_core_clk),
        .i_resetn     (i_resetn),
        .cfg          (cfg.sink),
        .o_cpu_mult   (o_cpu_mult),
        .o_cpu_div    (o_cpu_div),
        .o_gfx_mult   (o_gfx_mult),
        .o_gfx_div    (o_gfx_div),
        .o_cpu_spread (o_cpu_spread)
    );

endmodule : pllds_regs

// File: tb/pllds_regs_props.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// pin-level checks of the divider register block
// ------------------------------------------------------------
module pllds_regs_props
    import pllds_pkg::*;
(
    // clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_resetn,
    // straps and bus pins
    input wire logic [2:0]  i_freq_sel,
    input wire logic        i_smb_clk,
    input wire logic        i_smb_data,
    input wire logic        o_smb_data_out,
    input wire logic        o_smb_data_oe,
    // applied settings
    input wire logic [10:0] o_cpu_mult,
    input wire logic [6:0]  o_cpu_div,
    input wire logic [10:0] o_gfx_mult,
    input wire logic [6:0]  o_gfx_div,
    input wire logic [14:0] o_cpu_spread,
    input wire logic        o_prog_en
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    logic [2:0] age_reg;   // cycles since reset, saturating
    logic       frame_reg; // between start and stop
    logic [1:0] pin_reg;   // last {clock, data}

    // age hides the table load that follows reset
    always_ff @(posedge i_core_clk)
        if (!i_resetn) age_reg <= 3'h0;
        else if (age_reg != 3'h5) age_reg <= age_reg + 3'h1;

    // frame tracking from raw pin levels
    always_ff @(posedge i_core_clk)
        pin_reg <= {i_smb_clk, i_smb_data};
    always_ff @(posedge i_core_clk)
        if (!i_resetn) frame_reg <= 1'b0;
        else if (pin_reg == 2'b11 && i_smb_clk && !i_smb_data)
            frame_reg <= 1'b1;
        else if (pin_reg == 2'b10 && i_smb_clk && i_smb_data)
            frame_reg <= 1'b0;

    property p_rst_vals;
        $rose(i_resetn) |-> !o_prog_en && !o_smb_data_oe
            && o_cpu_spread == 15'h0000 && o_cpu_div == 7'h02;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not at reset values after release");

    property p_def_load;
        $rose(i_resetn) |-> ##[2:3] (o_cpu_mult ==
            {1'b0, PLLDS_DEF_TABLE[i_freq_sel][15:6]} + PLLDS_FB_ADD
            && o_cpu_div ==
            {1'b0, PLLDS_DEF_TABLE[i_freq_sel][5:0]} + PLLDS_REF_ADD);
    endproperty
    a_def_load: assert property (p_def_load)
        else $error("default table not applied after reset");

    property p_div_hold;
        age_reg == 3'h5 && !o_prog_en && !$past(o_prog_en) |->
            $stable(o_cpu_mult) && $stable(o_cpu_div)
            && $stable(o_gfx_mult) && $stable(o_gfx_div);
    endproperty
    a_div_hold: assert property (p_div_hold)
        else $error("dividers moved while programming disabled");

    property p_sp_hold;
        age_reg == 3'h5 && $changed(o_cpu_spread) |-> o_prog_en;
    endproperty
    a_sp_hold: assert property (p_sp_hold)
        else $error("spread moved while programming disabled");

    property p_od_low;
        o_smb_data_out == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("data pin driven high");

    property p_oe_clk_low;
        $changed(o_smb_data_oe) |-> !i_smb_clk;
    endproperty
    a_oe_clk_low: assert property (p_oe_clk_low)
        else $error("data drive changed while bus clock high");

    property p_oe_framed;
        o_smb_data_oe |-> frame_reg;
    endproperty
    a_oe_framed: assert property (p_oe_framed)
        else $error("data driven outside a frame");

    property p_range;
        age_reg == 3'h5 |-> o_cpu_div inside {[7'h02:7'h41]}
            && o_gfx_div inside {[7'h02:7'h41]}
            && o_cpu_mult inside {[11'h008:11'h407]};
    endproperty
    a_range: assert property (p_range)
        else $error("applied divider outside formula range");

    c_ack: cover property (o_smb_data_oe);
    c_en: cover property ($rose(o_prog_en));
    c_sp: cover property ($changed(o_cpu_spread));
endmodule : pllds_regs_props

bind pllds_regs pllds_regs_props u_props (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_freq_sel(i_freq_sel), .i_smb_clk(i_smb_clk),
    .i_smb_data(i_smb_data), .o_smb_data_out(o_smb_data_out),
    .o_smb_data_oe(o_smb_data_oe), .o_cpu_mult(o_cpu_mult),
    .o_cpu_div(o_cpu_div), .o_gfx_mult(o_gfx_mult),
    .o_gfx_div(o_gfx_div), .o_cpu_spread(o_cpu_spread),
    .o_prog_en(o_prog_en));

// File: tb/pllds_host_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// management bus host driving the register block
// ------------------------------------------------------------
module pllds_host_model
(
    // core clock paces the bit timing
    input  wire logic i_core_clk,
    // resolved data line level
    input  wire logic i_data_wire,
    // host side pins
    output logic      o_smb_clk,
    output logic      o_data_pull
);
    // idle: clock high, data released to the pull-up
    initial
    begin
        o_smb_clk   = 1'b1;
        o_data_pull = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : wait_n

    // data moves mid low phase so the device lag never races it
    task automatic put_bit(input logic b, output logic r);
        wait_n(4);
        o_data_pull = ~b;
        wait_n(4);
        o_smb_clk = 1'b1;
        wait_n(4);
        r = i_data_wire;
        o_smb_clk = 1'b0;
    endtask : put_bit

    // start doubles as repeated start
    task automatic start();
        o_data_pull = 1'b0;
        wait_n(8);
        o_smb_clk = 1'b1;
        wait_n(4);
        o_data_pull = 1'b1;
        wait_n(4);
        o_smb_clk = 1'b0;
    endtask : start

    task automatic stop();
        o_data_pull = 1'b1;
        wait_n(8);
        o_smb_clk = 1'b1;
        wait_n(4);
        o_data_pull = 1'b0;
        wait_n(4);
    endtask : stop

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask : put_byte

    task automatic get_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, r);
            b[i] = r;
        end
        put_bit(last, r);
    endtask : get_byte

    // write: address, offset, count, then the data bytes
    task automatic bus_wr(input logic [6:0] a, input logic [7:0] off,
                          input logic [7:0] q[$], output logic ok);
        logic ack;
        start();
        put_byte({a, 1'b0}, ok);
        if (ok)
        begin
            put_byte(off, ack);
            put_byte(8'(q.size()), ack);
            foreach (q[k])
                put_byte(q[k], ack);
        end
        stop();
    endtask : bus_wr

    // read: count byte then n data bytes, nack on the last
    task automatic bus_rd(input logic [6:0] a, input logic [7:0] off,
                          input int n, output logic [7:0] q[$]);
        logic       ack;
        logic [7:0] b;
        q = {};
        start();
        put_byte({a, 1'b0}, ack);
        put_byte(off, ack);
        start();
        put_byte({a, 1'b1}, ack);
        for (int k = 0; k <= n; k++)
        begin
            get_byte(k == n, b);
            q.push_back(b);
        end
        stop();
    endtask : bus_rd
endmodule : pllds_host_model

// File: tb/testbench.sv
`timescale 1ns/100ps

module testbench;
    import pllds_pkg::*;

    // ------------------------------------------------------------
    // clock, reset and pins
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    logic [2:0]  freq_sel = 3'h2;
    logic        smb_clk;
    logic        host_pull;
    logic        dut_oe;
    logic        dut_out;
    wire         data_wire;
    logic [10:0] cpu_mult;
    logic [6:0]  cpu_div;
    logic [10:0] gfx_mult;
    logic [6:0]  gfx_div;
    logic [14:0] cpu_spread;
    logic        prog_en;
    logic [7:0]  rdq[$];
    logic        ok;
    int          num_errors  = 0;
    int          comparisons = 0;

    // pull-up: high unless some party pulls low
    assign data_wire = ~(host_pull | dut_oe);
    always #2 core_clk = ~core_clk;

    pllds_regs u_dut (
        .i_core_clk(core_clk), .i_resetn(resetn),
        .i_freq_sel(freq_sel), .i_smb_clk(smb_clk),
        .i_smb_data(data_wire), .o_smb_data_out(dut_out),
        .o_smb_data_oe(dut_oe), .o_cpu_mult(cpu_mult),
        .o_cpu_div(cpu_div), .o_gfx_mult(gfx_mult),
        .o_gfx_div(gfx_div), .o_cpu_spread(cpu_spread),
        .o_prog_en(prog_en));

    pllds_host_model u_host (
        .i_core_clk(core_clk), .i_data_wire(data_wire),
        .o_smb_clk(smb_clk), .o_data_pull(host_pull));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [10:0] mult_of(input logic [7:0] hi,
                                            input logic [7:0] lo);
        return {1'b0, hi[6], hi[7], lo} + PLLDS_FB_ADD;
    endfunction : mult_of

    function automatic logic [6:0] div_of(input logic [7:0] hi);
        return {1'b0, hi[5:0]} + PLLDS_REF_ADD;
    endfunction : div_of

    // write must be acked; settle a few cycles before looking
    task automatic wr(input logic [7:0] off, input logic [7:0] q[$]);
        u_host.bus_wr(PLLDS_DEV_ADDR, off, q, ok);
        check(ok, 1'b1);
        repeat (4) @(negedge core_clk);
    endtask : wr

    task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp[$]);
        u_host.bus_rd(PLLDS_DEV_ADDR, off, exp.size(), rdq);
        check(rdq[0], PLLDS_RD_COUNT);
        foreach (exp[k])
            check(rdq[k + 1], exp[k]);
    endtask : rd_chk

    task automatic conclude();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] e;
        logic [7:0]  his[3];
        e = PLLDS_DEF_TABLE[freq_sel];
        his = '{8'h00, 8'h3F, 8'hFF};
        repeat (8) @(negedge core_clk);
        resetn = 1'b1;
        repeat (6) @(negedge core_clk);
        check(cpu_mult, {1'b0, e[15:6]} + PLLDS_FB_ADD);
        check(cpu_div, {1'b0, e[5:0]} + PLLDS_REF_ADD);
        check(prog_en, 1'b0);
        check(cpu_spread, 15'h0000);
        rd_chk(PLLDS_OFS_CPU_DIVHI, '{{e[14], e[15], e[5:0]}, e[13:6]});
        // spread code taken as given, set reserved bit too
        wr(PLLDS_OFS_CPU_DIVHI, '{8'hC5, 8'h3A, 8'h5A, 8'hFF, 8'h47, 8'h12});
        check(cpu_mult, {1'b0, e[15:6]} + PLLDS_FB_ADD);
        // reserved bit reads zero, unmapped byte reads zero
        rd_chk(PLLDS_OFS_CPU_DIVHI,
               '{8'hC5, 8'h3A, 8'h5A, 8'h7F, 8'h47, 8'h12, 8'h00});
        // enable applies all fields, dividers through the formula
        wr(PLLDS_OFS_PROG_EN, '{8'h80});
        check(prog_en, 1'b1);
        check(cpu_mult, mult_of(8'hC5, 8'h3A));
        check(cpu_div, 7'h07);
        check(gfx_mult, mult_of(8'h47, 8'h12));
        check(gfx_div, div_of(8'h47));
        check(cpu_spread, 15'h7F5A);
        // boundary values of the high divider byte
        foreach (his[k])
        begin
            wr(PLLDS_OFS_CPU_DIVHI, '{his[k]});
            check(cpu_mult, mult_of(his[k], 8'h3A));
            check(cpu_div, div_of(his[k]));
        end
        // foreign address is not acked and stores nothing
        u_host.bus_wr(PLLDS_DEV_ADDR ^ 7'h01, PLLDS_OFS_CPU_DIVHI,
                      '{8'h00}, ok);
        check(ok, 1'b0);
        check(cpu_div, div_of(8'hFF));
        // clearing enable freezes outputs, field still stored
        wr(PLLDS_OFS_PROG_EN, '{8'h00});
        wr(PLLDS_OFS_CPU_FBLO, '{8'h01});
        check(prog_en, 1'b0);
        check(cpu_mult, mult_of(8'hFF, 8'h3A));
        rd_chk(PLLDS_OFS_CPU_DIVHI, '{8'hFF, 8'h01});
        conclude();
    end

    // watchdog: the tests need well under 30k cycles
    initial
    begin
        repeat (80000) @(posedge core_clk);
        num_errors++;
        conclude();
    end
endmodule : testbench
